// [rtl/uirq_pkg.sv]
/*
 * constants of the usb device interrupt register block: offsets, fields,
 * reset values and timing.
 * assumes a 10 MHz aclk and 32-bit AXI4-Lite data.
 */
// Operation
// - disable write of one clears suspend, resume, frame or wakeup mask bit
// - enable write of one sets endpoint mask bit; zero does nothing
// - disable write of one clears endpoint mask bit; zero does nothing
// - mask register reads one for each enabled endpoint interrupt
// - mask register reads suspend, resume, frame and wakeup enables
// - mask bit 12 always reads one regardless of writes
// - resume mask bit is enabled out of reset
// - endpoint status raised by setup, bank data, transmit done or stall flag
// - endpoint status stays until software clears the cause flag
// - suspend status set after 3 ms without bus activity
// - resume status set whenever resume signalling is detected
// - resume status undefined after reset; software clears it first
// - frame start status set on each start-of-frame token
// - bus reset done status set when a bus reset finishes
// - wakeup status set on host resume or reset since last clear
// - wakeup status undefined after reset; software clears it
// - clear write of one clears suspend, resume, frame or reset-done status
// - clear write of one clears wakeup status
package uirq_pkg;

    // ***********************
    // register offsets
    // ***********************
    localparam int unsigned ADDR_W   = 8;
    localparam logic [7:0]  OFS_IER  = 8'h10;
    localparam logic [7:0]  OFS_IDR  = 8'h14;
    localparam logic [7:0]  OFS_IMR  = 8'h18;
    localparam logic [7:0]  OFS_ISR  = 8'h1C;
    localparam logic [7:0]  OFS_ICR  = 8'h20;

    // ***********************
    // field positions
    // ***********************
    localparam int unsigned NUM_EP            = 4;
    localparam int unsigned BIT_SUSPEND       = 8;
    localparam int unsigned BIT_RESUME        = 9;
    localparam int unsigned BIT_FRAME_START   = 11;
    localparam int unsigned BIT_UNMASKABLE    = 12;
    localparam int unsigned BIT_RESET_DONE    = 12;
    localparam int unsigned BIT_WAKEUP        = 13;
    localparam logic [31:0] MASK_WR_BITS      = 32'h0000_2B0F;
    localparam logic [31:0] STAT_CLR_BITS     = 32'h0000_3B00;
    localparam logic [31:0] MASK_RESET        = 32'h0000_0200;
    localparam logic [31:0] STAT_RESET        = 32'h0000_0000;

    // ***********************
    // axi responses
    // ***********************
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // ***********************
    // timing
    // ***********************
    localparam int unsigned CLK_PERIOD_NS       = 100;
    localparam int unsigned SUSPEND_IDLE_US     = 3000;
    localparam int unsigned SUSPEND_IDLE_CYCLES =
        (SUSPEND_IDLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// [rtl/uirq_reg_if.sv]
/*
 * register access carrier between the bus slave and the register block.
 * assumes both ends on aclk; write is a one-cycle pulse, read is combinational.
 */
`timescale 1ns/100ps
interface uirq_reg_if;
    logic        wr_valid;
    logic [7:0]  wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic        wr_hit;
    logic [7:0]  rd_addr;
    logic [31:0] rd_data;
    logic        rd_hit;

    modport bus  (output wr_valid, wr_addr, wr_data, wr_strb, rd_addr,
                  input  wr_hit, rd_data, rd_hit);
    modport regs (input  wr_valid, wr_addr, wr_data, wr_strb, rd_addr,
                  output wr_hit, rd_data, rd_hit);
endinterface

// [rtl/uirq_axil_slave.sv]
/*
 * AXI4-Lite slave turning bus transfers into register pulses.
 * assumes the register side answers hits and read data combinationally.
 */
`timescale 1ns/100ps
module uirq_axil_slave
    import uirq_pkg::*;
(
    // clock and reset
    input  wire logic          aclk,
    input  wire logic          aresetn,
    // write channels
    input  wire logic [7:0]    awaddr,
    input  wire logic          awvalid,
    output logic               awready,
    input  wire logic [31:0]   wdata,
    input  wire logic [3:0]    wstrb,
    input  wire logic          wvalid,
    output logic               wready,
    output logic [1:0]         bresp,
    output logic               bvalid,
    input  wire logic          bready,
    // read channels
    input  wire logic [7:0]    araddr,
    input  wire logic          arvalid,
    output logic               arready,
    output logic [31:0]        rdata,
    output logic [1:0]         rresp,
    output logic               rvalid,
    input  wire logic          rready,
    // register side
    uirq_reg_if.bus            rif
);
    logic aw_full_r;
    logic w_full_r;

    assign awready      = !aw_full_r && !bvalid;
    assign wready       = !w_full_r && !bvalid;
    assign arready      = !rvalid;
    assign rif.wr_valid = aw_full_r && w_full_r && !bvalid;
    assign rif.rd_addr  = araddr;

    // *************************
    // write path
    // *************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_r   <= 1'b0;
            w_full_r    <= 1'b0;
            rif.wr_addr <= 8'h00;
            rif.wr_data <= 32'h0000_0000;
            rif.wr_strb <= 4'h0;
            bvalid      <= 1'b0;
            bresp       <= RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_full_r   <= 1'b1;
                rif.wr_addr <= awaddr;
            end
            if (wvalid && wready) begin
                w_full_r    <= 1'b1;
                rif.wr_data <= wdata;
                rif.wr_strb <= wstrb;
            end
            if (rif.wr_valid) begin
                aw_full_r <= 1'b0;
                w_full_r  <= 1'b0;
                bvalid    <= 1'b1;
                bresp     <= rif.wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // *************************
    // read path
    // *************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata  <= rif.rd_data;
            rresp  <= rif.rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end
endmodule

// [rtl/uirq_idle_timer.sv]
/*
 * bus idle timer raising a one-cycle pulse after a run of idle cycles.
 * assumes bus_active comes from logic on aclk.
 */
`timescale 1ns/100ps
module uirq_idle_timer #(
    parameter int unsigned IDLE_CYCLES = 30000
) (
    // clock and reset
    input  wire logic  aclk,
    input  wire logic  aresetn,
    // bus state
    input  wire logic  bus_active,
    output logic       idle_pulse,
    output logic       suspended
);
    localparam int unsigned CNT_W = $clog2(IDLE_CYCLES + 1);
    localparam logic [CNT_W-1:0] LAST = CNT_W'(IDLE_CYCLES - 1);

    logic [CNT_W-1:0] count_r;

    always_ff @(posedge aclk) begin
        if (!aresetn || bus_active) begin
            count_r    <= '0;
            suspended  <= 1'b0;
            idle_pulse <= 1'b0;
        end else if (!suspended && count_r == LAST) begin
            suspended  <= 1'b1;
            idle_pulse <= 1'b1;
        end else begin
            idle_pulse <= 1'b0;
            if (!suspended) begin
                count_r <= count_r + CNT_W'(1);
            end
        end
    end
endmodule

// [rtl/uirq_usb_irq_regs.sv]
/*
 * interrupt enable, disable, mask, status and clear logic of a usb device port.
 * assumes endpoint cause flags and bus events arrive from port logic on aclk;
 * event inputs are one-cycle pulses, cause flags and bus activity are levels.
 */
`timescale 1ns/100ps
module uirq_usb_irq_regs
    import uirq_pkg::*;
#(
    parameter int unsigned SUSPEND_CYCLES = SUSPEND_IDLE_CYCLES
) (
    // clock and reset
    input  wire logic                aclk,
    input  wire logic                aresetn,
    // axi write address
    input  wire logic [ADDR_W-1:0]   awaddr,
    input  wire logic                awvalid,
    output logic                     awready,
    // axi write data
    input  wire logic [31:0]         wdata,
    input  wire logic [3:0]          wstrb,
    input  wire logic                wvalid,
    output logic                     wready,
    // axi write response
    output logic [1:0]               bresp,
    output logic                     bvalid,
    input  wire logic                bready,
    // axi read address
    input  wire logic [ADDR_W-1:0]   araddr,
    input  wire logic                arvalid,
    output logic                     arready,
    // axi read data
    output logic [31:0]              rdata,
    output logic [1:0]               rresp,
    output logic                     rvalid,
    input  wire logic                rready,
    // endpoint cause flags, one bit per endpoint
    input  wire logic [NUM_EP-1:0]   setup_received_flag,
    input  wire logic [NUM_EP-1:0]   bank_a_received_flag,
    input  wire logic [NUM_EP-1:0]   bank_b_received_flag,
    input  wire logic [NUM_EP-1:0]   transmit_done_flag,
    input  wire logic [NUM_EP-1:0]   stall_handshake_flag,
    // bus events from the port
    input  wire logic                bus_activity,
    input  wire logic                resume_detect,
    input  wire logic                frame_start_detect,
    input  wire logic                bus_reset_detect,
    input  wire logic                bus_reset_done,
    // outputs
    output logic                     irq,
    output logic                     bus_suspended
);

    // ***********************
    // bus slave
    // ***********************
    uirq_reg_if rif ();

    uirq_axil_slave u_slave (
        .aclk    (aclk),
        .aresetn (aresetn),
        .awaddr  (awaddr),
        .awvalid (awvalid),
        .awready (awready),
        .wdata   (wdata),
        .wstrb   (wstrb),
        .wvalid  (wvalid),
        .wready  (wready),
        .bresp   (bresp),
        .bvalid  (bvalid),
        .bready  (bready),
        .araddr  (araddr),
        .arvalid (arvalid),
        .arready (arready),
        .rdata   (rdata),
        .rresp   (rresp),
        .rvalid  (rvalid),
        .rready  (rready),
        .rif     (rif)
    );

    // ***********************
    // suspend timer
    // ***********************
    logic suspend_pulse;

    uirq_idle_timer #(
        .IDLE_CYCLES (SUSPEND_CYCLES)
    ) u_idle (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .bus_active (bus_activity),
        .idle_pulse (suspend_pulse),
        .suspended  (bus_suspended)
    );

    // ***********************
    // write decode
    // ***********************
    logic [31:0] strb_bits;
    logic [31:0] wr_bits;
    logic        wr_ier;
    logic        wr_idr;
    logic        wr_icr;

    assign strb_bits = {{8{rif.wr_strb[3]}}, {8{rif.wr_strb[2]}},
                        {8{rif.wr_strb[1]}}, {8{rif.wr_strb[0]}}};
    assign wr_bits   = rif.wr_data & strb_bits;
    assign wr_ier    = rif.wr_valid && rif.wr_addr == OFS_IER;
    assign wr_idr    = rif.wr_valid && rif.wr_addr == OFS_IDR;
    assign wr_icr    = rif.wr_valid && rif.wr_addr == OFS_ICR;

    always_comb begin
        unique case (rif.wr_addr)
            OFS_IER, OFS_IDR, OFS_IMR, OFS_ISR, OFS_ICR: rif.wr_hit = 1'b1;
            default:                                     rif.wr_hit = 1'b0;
        endcase
    end

    // ***********************
    // mask register
    // ***********************
    logic [31:0] mask_r;
    logic [31:0] mask_nxt;
    logic [31:0] mask_eff;

    always_comb begin
        mask_nxt = mask_r;
        if (wr_ier) begin
            mask_nxt = mask_nxt | (wr_bits & MASK_WR_BITS);
        end
        if (wr_idr) begin
            mask_nxt = mask_nxt & ~(wr_bits & MASK_WR_BITS);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask_r <= MASK_RESET;
        end else begin
            mask_r <= mask_nxt;
        end
    end

    // unmaskable bit forced high
    assign mask_eff = mask_r | (32'h0000_0001 << BIT_UNMASKABLE);

    // ***********************
    // endpoint status
    // ***********************
    logic [NUM_EP-1:0] ep_stat_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ep_stat_r <= '0;
        end else begin
            ep_stat_r <= setup_received_flag | bank_a_received_flag
                       | bank_b_received_flag | transmit_done_flag
                       | stall_handshake_flag;
        end
    end

    // ***********************
    // bus event status
    // ***********************
    logic [31:0] ev_set;
    logic [31:0] ev_clr;
    logic [31:0] ev_stat_r;
    logic [31:0] status;

    always_comb begin
        ev_set = 32'h0000_0000;
        ev_set[BIT_SUSPEND]     = suspend_pulse;
        ev_set[BIT_RESUME]      = resume_detect;
        ev_set[BIT_FRAME_START] = frame_start_detect;
        ev_set[BIT_RESET_DONE]  = bus_reset_done;
        ev_set[BIT_WAKEUP]      = resume_detect | bus_reset_detect;
        ev_clr = wr_icr ? (wr_bits & STAT_CLR_BITS) : 32'h0000_0000;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ev_stat_r <= STAT_RESET;
        end else begin
            ev_stat_r <= (ev_stat_r & ~ev_clr) | ev_set;
        end
    end

    assign status = ev_stat_r | {{(32-NUM_EP){1'b0}}, ep_stat_r};

    // ***********************
    // read decode
    // ***********************
    always_comb begin
        rif.rd_hit  = 1'b1;
        rif.rd_data = 32'h0000_0000;
        unique case (rif.rd_addr)
            OFS_IMR:                   rif.rd_data = mask_eff;
            OFS_ISR:                   rif.rd_data = status;
            OFS_IER, OFS_IDR, OFS_ICR: rif.rd_data = 32'h0000_0000;
            default:                   rif.rd_hit  = 1'b0;
        endcase
    end

    // ***********************
    // interrupt output
    // ***********************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status & mask_eff);
        end
    end

    // ***********************
    // assertions
    // ***********************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_idr_susp;
        wr_idr && wr_bits[BIT_SUSPEND] |=> !mask_r[BIT_SUSPEND] && !mask_eff[BIT_SUSPEND];
    endproperty
    a_idr_susp: assert property (p_idr_susp) else $error("suspend mask not cleared");

    property p_ier_ep;
        wr_ier && wr_bits[0] |=> mask_r[0];
    endproperty
    a_ier_ep: assert property (p_ier_ep) else $error("endpoint mask not set");

    property p_idr_ep;
        wr_idr && wr_bits[2] |=> !mask_r[2];
    endproperty
    a_idr_ep: assert property (p_idr_ep) else $error("endpoint mask not cleared");

    property p_imr_read;
        arvalid && arready && araddr == OFS_IMR
            |=> rvalid && rdata[3:0] == $past(mask_r[3:0]) && rdata[12];
    endproperty
    a_imr_read: assert property (p_imr_read) else $error("mask read mismatch");

    property p_resume_mask_reset;
        $rose(aresetn) |-> mask_r[BIT_RESUME];
    endproperty
    a_resume_mask_reset: assert property (@(posedge aclk) p_resume_mask_reset)
        else $error("resume mask not set after reset");

    property p_ep_status;
        stall_handshake_flag[1] |=> status[1];
    endproperty
    a_ep_status: assert property (p_ep_status) else $error("endpoint status missing");

    property p_suspend;
        suspend_pulse |=> ev_stat_r[BIT_SUSPEND] && bus_suspended;
    endproperty
    a_suspend: assert property (p_suspend) else $error("suspend status missing");

    property p_wakeup;
        (resume_detect || bus_reset_detect) |=> ev_stat_r[BIT_WAKEUP];
    endproperty
    a_wakeup: assert property (p_wakeup) else $error("wakeup status missing");

    property p_sof_clear;
        wr_icr && wr_bits[BIT_FRAME_START] && !frame_start_detect
            |=> !ev_stat_r[BIT_FRAME_START];
    endproperty
    a_sof_clear: assert property (p_sof_clear) else $error("frame status not cleared");

    property p_irq;
        ev_stat_r[BIT_RESET_DONE] |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("unmaskable event without irq");

    c_irq_rise:   cover property ($rose(irq));
    c_suspend:    cover property (suspend_pulse);
    c_wr_then_rd: cover property (wr_ier ##[1:20] (rvalid && rready));
endmodule

// [verif/uirq_port_model.sv]
/*
 * model of the usb port logic feeding endpoint cause flags and bus events.
 * assumes the bench calls its tasks right after a rising edge of aclk.
 */
`timescale 1ns/100ps
module uirq_port_model
    import uirq_pkg::*;
(
    // clock
    input  wire logic          aclk,
    // endpoint cause flags
    output logic [NUM_EP-1:0]  setup_received_flag,
    output logic [NUM_EP-1:0]  bank_a_received_flag,
    output logic [NUM_EP-1:0]  bank_b_received_flag,
    output logic [NUM_EP-1:0]  transmit_done_flag,
    output logic [NUM_EP-1:0]  stall_handshake_flag,
    // bus events
    output logic               bus_activity,
    output logic               resume_detect,
    output logic               frame_start_detect,
    output logic               bus_reset_detect,
    output logic               bus_reset_done
);
    initial begin
        {setup_received_flag, bank_a_received_flag, bank_b_received_flag} = 12'h000;
        {transmit_done_flag, stall_handshake_flag} = 8'h00;
        {resume_detect, frame_start_detect, bus_reset_detect, bus_reset_done} = 4'h0;
        bus_activity = 1'h1;
    end

    // one-cycle event: 0 resume, 1 frame start, 2 bus reset, 3 reset done
    task automatic pulse(input int kind);
        @(posedge aclk);
        resume_detect      <= (kind == 0);
        frame_start_detect <= (kind == 1);
        bus_reset_detect   <= (kind == 2);
        bus_reset_done     <= (kind == 3);
        @(posedge aclk);
        {resume_detect, frame_start_detect, bus_reset_detect, bus_reset_done} <= 4'h0;
    endtask

    // cause level: 0 setup, 1 bank a, 2 bank b, 3 transmit done, 4 stall
    task automatic set_cause(input int kind, input logic [NUM_EP-1:0] v);
        @(posedge aclk);
        case (kind)
            0: setup_received_flag <= v;
            1: bank_a_received_flag <= v;
            2: bank_b_received_flag <= v;
            3: transmit_done_flag <= v;
            default: stall_handshake_flag <= v;
        endcase
        // status registers the flag one edge later
        @(posedge aclk);
    endtask

    task automatic set_activity(input logic on);
        @(posedge aclk);
        bus_activity <= on;
    endtask
endmodule

// [verif/uirq_usb_irq_regs_tb.sv]
/*
 * self-checking bench of the usb interrupt register block over AXI4-Lite.
 * assumes the port model drives events; expectations follow the package.
 */
`timescale 1ns/100ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin miscompares++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, got, exp); end end
module uirq_usb_irq_regs_tb
    import uirq_pkg::*;
;
    // ***********************
    // signals
    // ***********************
    localparam int unsigned SUSP = 20;
    logic               aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0]         awaddr, araddr;
    logic [31:0]        wdata, rdata, rd_d, exp_m;
    logic [3:0]         wstrb;
    logic [1:0]         bresp, rresp, rd_r, wr_resp;
    logic               awready, wready, bvalid, arready, rvalid, irq, bus_suspended;
    logic [NUM_EP-1:0]  su_f, ba_f, bb_f, tx_f, st_f;
    logic               act, rsm, sof, brst, bdone;
    int                 miscompares, num_checks, i;
    int unsigned        dis_pos [8] = '{0, 1, 2, 3, 8, 9, 11, 13};

    uirq_usb_irq_regs #(.SUSPEND_CYCLES(SUSP)) dut (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .setup_received_flag(su_f),
        .bank_a_received_flag(ba_f), .bank_b_received_flag(bb_f),
        .transmit_done_flag(tx_f), .stall_handshake_flag(st_f), .bus_activity(act),
        .resume_detect(rsm), .frame_start_detect(sof), .bus_reset_detect(brst),
        .bus_reset_done(bdone), .irq(irq), .bus_suspended(bus_suspended));

    uirq_port_model port_m (
        .aclk(aclk), .setup_received_flag(su_f), .bank_a_received_flag(ba_f),
        .bank_b_received_flag(bb_f), .transmit_done_flag(tx_f),
        .stall_handshake_flag(st_f), .bus_activity(act), .resume_detect(rsm),
        .frame_start_detect(sof), .bus_reset_detect(brst), .bus_reset_done(bdone));

    always #50 aclk = ~aclk;

    // ***********************
    // bus tasks
    // ***********************
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge aclk);
            awvalid <= awvalid && !awready;
            wvalid <= wvalid && !wready;
        end while (!bvalid);
        wr_resp = bresp;
        bready <= 1'h0;
        @(posedge aclk);
    endtask

    task automatic axi_read(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge aclk);
            arvalid <= arvalid && !arready;
        end while (!rvalid);
        rd_d = rdata;
        rd_r = rresp;
        rready <= 1'h0;
        @(posedge aclk);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        axi_read(a);
        `CHK(rd_r, RESP_OKAY)
        `CHK(rd_d, e)
    endtask

    task automatic chk_irq(input logic e);
        @(negedge aclk);
        `CHK(irq, e)
        @(posedge aclk);
    endtask

    task automatic wrap_up;
        if (miscompares == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ***********************
    // tests
    // ***********************
    initial begin
        aclk = 1'h0; aresetn = 1'h0; awvalid = 1'h0; wvalid = 1'h0; bready = 1'h0;
        arvalid = 1'h0; rready = 1'h0; awaddr = 8'h00; araddr = 8'h00;
        wdata = 32'h0; wstrb = 4'h0; miscompares = 0; num_checks = 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        rd_chk(OFS_IMR, 32'h0000_1200);
        axi_write(OFS_ICR, 32'h0000_3B00, 4'hF);
        rd_chk(OFS_ISR, 32'h0000_0000);
        exp_m = 32'h0000_1200;
        for (i = 0; i < 8; i++) begin
            axi_write(OFS_IER, 32'h1 << dis_pos[i], 4'hF);
            exp_m = exp_m | (32'h1 << dis_pos[i]);
            rd_chk(OFS_IMR, exp_m);
        end
        rd_chk(OFS_IMR, 32'h0000_3B0F);
        axi_write(OFS_IDR, 32'h0000_0000, 4'hF);
        axi_write(OFS_IMR, 32'h0000_0000, 4'hF);
        `CHK(wr_resp, RESP_OKAY)
        axi_write(OFS_IDR, 32'h0000_000F, 4'h2);
        rd_chk(OFS_IMR, 32'h0000_3B0F);
        for (i = 0; i < 8; i++) begin
            axi_write(OFS_IDR, 32'h1 << dis_pos[i], 4'hF);
            exp_m = exp_m & ~(32'h1 << dis_pos[i]);
            rd_chk(OFS_IMR, exp_m);
        end
        axi_write(OFS_IER, 32'h0000_000F, 4'hF);
        for (i = 0; i < 5; i++) begin
            port_m.set_cause(i, 4'h1 << (i % 4));
            rd_chk(OFS_ISR, 32'h1 << (i % 4));
            chk_irq(1'h1);
            axi_write(OFS_ICR, 32'h0000_3B0F, 4'hF);
            rd_chk(OFS_ISR, 32'h1 << (i % 4));
            port_m.set_cause(i, 4'h0);
            rd_chk(OFS_ISR, 32'h0000_0000);
            chk_irq(1'h0);
        end
        port_m.pulse(0);
        rd_chk(OFS_ISR, 32'h0000_2200);
        chk_irq(1'h0);
        axi_write(OFS_IER, 32'h0000_0200, 4'hF);
        chk_irq(1'h1);
        axi_write(OFS_ICR, 32'h0000_0000, 4'hF);
        rd_chk(OFS_ISR, 32'h0000_2200);
        axi_write(OFS_ICR, 32'h0000_0200, 4'hF);
        rd_chk(OFS_ISR, 32'h0000_2000);
        axi_write(OFS_ICR, 32'h0000_2000, 4'hF);
        rd_chk(OFS_ISR, 32'h0000_0000);
        port_m.pulse(1);
        rd_chk(OFS_ISR, 32'h0000_0800);
        axi_write(OFS_ICR, 32'h0000_0800, 4'hF);
        port_m.pulse(2);
        rd_chk(OFS_ISR, 32'h0000_2000);
        axi_write(OFS_ICR, 32'h0000_2000, 4'hF);
        port_m.pulse(3);
        rd_chk(OFS_ISR, 32'h0000_1000);
        chk_irq(1'h1);
        axi_write(OFS_ICR, 32'h0000_1000, 4'hF);
        rd_chk(OFS_ISR, 32'h0000_0000);
        port_m.set_activity(1'h0);
        repeat (8) @(posedge aclk);
        rd_chk(OFS_ISR, 32'h0000_0000);
        repeat (SUSP) @(posedge aclk);
        rd_chk(OFS_ISR, 32'h0000_0100);
        `CHK(bus_suspended, 1'h1)
        port_m.set_activity(1'h1);
        axi_write(OFS_ICR, 32'h0000_0100, 4'hF);
        rd_chk(OFS_ISR, 32'h0000_0000);
        axi_read(8'h40);
        `CHK(rd_r, RESP_SLVERR)
        `CHK(rd_d, 32'h0000_0000)
        axi_write(8'h44, 32'h0000_000F, 4'hF);
        `CHK(wr_resp, RESP_SLVERR)
        wrap_up();
    end

    // ***********************
    // watchdog
    // ***********************
    initial begin
        repeat (5000) @(posedge aclk);
        miscompares++;
        wrap_up();
    end
endmodule
